// ==== pcm_pkg.sv ====
// shared constants and carrier types of the pixel-correction and motor configuration bank
package pcm_pkg;
    // bus geometry
    localparam int unsigned AW          = 12;
    localparam int unsigned NREG        = 12;
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_OFS_HI  = 8'h3e;
    localparam logic [7:0]  IDX_OFS_LO  = 8'h3f;
    localparam logic [7:0]  IDX_GAIN_HI = 8'h40;
    localparam logic [7:0]  IDX_GAIN_LO = 8'h41;
    localparam logic [7:0]  IDX_SRC_CFG = 8'h42;
    localparam logic [7:0]  IDX_KEEP_T  = 8'h43;
    localparam logic [7:0]  IDX_PERIOD  = 8'h44;
    localparam logic [7:0]  IDX_MOTOR   = 8'h45;
    localparam logic [7:0]  IDX_SCAN_HI = 8'h46;
    localparam logic [7:0]  IDX_SCAN_LO = 8'h47;
    localparam logic [7:0]  IDX_FAST_HI = 8'h48;
    localparam logic [7:0]  IDX_FAST_LO = 8'h49;
    // reset value of every register
    localparam logic [7:0]  REG_RST     = 8'h00;
    // source / shading config fields
    localparam int unsigned CFG_MUL_BYP = 0;
    localparam int unsigned CFG_GAIN_DR = 1;
    localparam int unsigned CFG_OFS_DR  = 2;
    localparam int unsigned CFG_DR_SIZE = 6;
    // motor mode fields
    localparam int unsigned MOT_MICRO   = 0;
    localparam int unsigned MOT_SENSE2  = 1;
    localparam int unsigned MOT_POL_A   = 2;
    localparam int unsigned MOT_POL_B   = 3;
    localparam int unsigned MOT_DRIVE   = 4;
    // gain scale 16384 = 2**14
    localparam int unsigned GAIN_SHIFT  = 14;
    localparam logic [8:0]  KEEP_BASE   = 9'h100;
    localparam logic [15:0] STEP_MIN    = 16'h0002;
    localparam logic [1:0]  MICRO_WRAP  = 2'h3;
    // bus answers
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic          awvalid;
        logic [AW-1:0] awaddr;
        logic          wvalid;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          bready;
        logic          arvalid;
        logic [AW-1:0] araddr;
        logic          rready;
    } pcm_axi_req_t;

    typedef struct packed {
        logic          awready;
        logic          wready;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          arready;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
    } pcm_axi_rsp_t;

    typedef struct packed {
        logic          valid;
        logic [15:0]   data;
        logic [15:0]   dram_gain;
        logic [15:0]   dram_ofs;
    } pcm_pix_in_t;

    typedef struct packed {
        logic          valid;
        logic [15:0]   data;
    } pcm_pix_out_t;

    typedef struct packed {
        logic [3:0]    drv;
        logic [3:0]    oe;
        logic          micro_mode;
        logic          sense_two;
        logic          step;
    } pcm_motor_t;
endpackage

// ==== pcm_top.sv ====
// register bank, pixel correction, line skipping and motor stepping of the scanner slice
//
// Summary of operation
// - fixed offset comes from 0x3e high and 0x3f low when fixed source chosen
// - fixed gain comes from 0x40 high and 0x41 low when fixed source chosen
// - 0x42 bit0 low scales pixel by gain/16384; high bypasses multiplier
// - 0x42 bit1 picks gain source: 0 fixed pair, 1 per-pixel DRAM value
// - 0x42 bit2 picks offset source: 0 fixed pair, 1 per-pixel DRAM value
// - 0x43 holds t; keep 256-t lines of every m; t zero bypasses
// - 0x44 holds period m; m zero bypasses line skipping
// - 0x45 bit0 selects full-step (0) or microstepping (1)
// - 0x45 bit1 selects one-phase (0) or two-phase (1) current sensing
// - 0x45 bits 2,3 invert winding A and B outputs when set
// - 0x45 bit4 enables the four phase outputs; zero floats them
// - 0x46/0x47 give scanning microstep length in pixel periods
// - 0x48/0x49 give fast-feed microstep length; at least 2
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module pcm_top
    import pcm_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire pcm_pkg::pcm_axi_req_t axi_req,
    output      pcm_pkg::pcm_axi_rsp_t axi_rsp,
    input  wire pcm_pkg::pcm_pix_in_t  pix_in,
    output      pcm_pkg::pcm_pix_out_t pix_out,
    output      logic                  dram_large,
    input  wire logic                  line_end,
    output      logic                  line_done,
    output      logic                  line_store,
    input  wire logic                  motor_run,
    input  wire logic                  fast_feed,
    input  wire logic                  pixel_tick,
    output      pcm_pkg::pcm_motor_t   motor
);
    import pcm_pkg::*;

    // whole module state
    typedef struct packed {
        pcm_axi_rsp_t            rsp;
        logic                    aw_held;
        logic                    w_held;
        logic [AW-1:0]           waddr;
        logic [7:0]              wbyte;
        logic                    wlane;
        logic [NREG-1:0][7:0]    regs;
        pcm_pix_out_t            pix;
        logic [7:0]              line_cnt;
        logic                    line_done;
        logic                    line_store;
        logic [15:0]             step_cnt;
        logic [1:0]              micro_cnt;
        logic [1:0]              phase;
        pcm_motor_t              mot;
    } pcm_state_t;

    pcm_state_t st_r;
    pcm_state_t st_nxt;

    // address decode: {hit, register slot}
    function automatic logic [4:0] reg_map(input logic [AW-1:0] addr);
        logic [AW-3:0] word;
        logic [AW-3:0] slot;
        logic          hit;
        word = addr[AW-1:2];
        slot = word - {2'h0, IDX_OFS_HI};
        hit  = (addr[1:0] == 2'h0) && (word >= {2'h0, IDX_OFS_HI}) && (word <= {2'h0, IDX_FAST_LO});
        return {hit, slot[3:0]};
    endfunction

    // slot of a register index
    function automatic logic [3:0] slot_of(input logic [7:0] idx);
        logic [7:0] d;
        d = idx - IDX_OFS_HI;
        return d[3:0];
    endfunction

    // join a high and a low byte
    function automatic logic [15:0] word16(input logic [7:0] hi, input logic [7:0] lo);
        return {hi, lo};
    endfunction

    // combinational working values
    logic [4:0]  wmap;
    logic [4:0]  rmap;
    logic [7:0]  cfg;
    logic [7:0]  mcfg;
    logic [15:0] fix_ofs;
    logic [15:0] fix_gain;
    logic [15:0] ofs;
    logic [15:0] gain;
    logic [15:0] diff;
    logic [31:0] prod;
    logic [17:0] scaled;
    logic [15:0] corr;
    logic [7:0]  keep_t;
    logic [7:0]  period;
    logic [8:0]  keep_n;
    logic        skip_byp;
    logic [7:0]  cnt_inc;
    logic [15:0] size_raw;
    logic [15:0] size;
    logic [15:0] step_inc;
    logic        step_now;
    logic [3:0]  pattern;
    logic [3:0]  pol;

    always_comb begin
        st_nxt = st_r;

        // pair joining, always the latest bytes
        cfg      = st_r.regs[slot_of(IDX_SRC_CFG)];
        mcfg     = st_r.regs[slot_of(IDX_MOTOR)];
        fix_ofs  = word16(st_r.regs[slot_of(IDX_OFS_HI)], st_r.regs[slot_of(IDX_OFS_LO)]);
        fix_gain = word16(st_r.regs[slot_of(IDX_GAIN_HI)], st_r.regs[slot_of(IDX_GAIN_LO)]);
        keep_t   = st_r.regs[slot_of(IDX_KEEP_T)];
        period   = st_r.regs[slot_of(IDX_PERIOD)];

        // write address and data, taken in either order
        if (axi_req.awvalid && st_r.rsp.awready) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.waddr   = axi_req.awaddr;
        end
        if (axi_req.wvalid && st_r.rsp.wready) begin
            st_nxt.w_held = 1'b1;
            st_nxt.wbyte  = axi_req.wdata[7:0];
            st_nxt.wlane  = axi_req.wstrb[0];
        end
        if (st_r.rsp.bvalid && axi_req.bready) begin
            st_nxt.rsp.bvalid = 1'b0;
        end
        // commit once both halves are held
        wmap = reg_map(st_r.waddr);
        if (st_r.aw_held && st_r.w_held && !st_r.rsp.bvalid) begin
            st_nxt.aw_held    = 1'b0;
            st_nxt.w_held     = 1'b0;
            st_nxt.rsp.bvalid = 1'b1;
            st_nxt.rsp.bresp  = wmap[4] ? RESP_OKAY : RESP_SLVERR;
            if (wmap[4] && st_r.wlane) begin
                st_nxt.regs[wmap[3:0]] = st_r.wbyte;
            end
        end
        st_nxt.rsp.awready = !st_nxt.aw_held && !st_nxt.rsp.bvalid;
        st_nxt.rsp.wready  = !st_nxt.w_held && !st_nxt.rsp.bvalid;

        // read channel, one at a time
        rmap = reg_map(axi_req.araddr);
        if (st_r.rsp.rvalid && axi_req.rready) begin
            st_nxt.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && st_r.rsp.arready) begin
            st_nxt.rsp.rvalid = 1'b1;
            st_nxt.rsp.rresp  = rmap[4] ? RESP_OKAY : RESP_SLVERR;
            st_nxt.rsp.rdata  = rmap[4] ? {24'h000000, st_r.regs[rmap[3:0]]} : 32'h00000000;
        end
        st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

        // coefficient sources
        ofs  = cfg[CFG_OFS_DR] ? pix_in.dram_ofs : fix_ofs;
        gain = cfg[CFG_GAIN_DR] ? pix_in.dram_gain : fix_gain;

        // offset removal then shading gain, clamped to 16 bits
        diff   = (pix_in.data > ofs) ? (pix_in.data - ofs) : 16'h0000;
        prod   = {16'h0000, diff} * {16'h0000, gain};
        scaled = prod[GAIN_SHIFT +: 18];
        corr   = (scaled[17:16] != 2'h0) ? 16'hffff : scaled[15:0];
        st_nxt.pix.valid = pix_in.valid;
        st_nxt.pix.data  = cfg[CFG_MUL_BYP] ? diff : corr;

        // n out of m line skipping
        keep_n   = KEEP_BASE - {1'b0, keep_t};
        skip_byp = (keep_t == 8'h00) || (period == 8'h00);
        cnt_inc  = st_r.line_cnt + 8'h01;
        st_nxt.line_done  = line_end;
        st_nxt.line_store = 1'b0;
        if (line_end) begin
            st_nxt.line_store = skip_byp || ({1'b0, st_r.line_cnt} < keep_n);
            st_nxt.line_cnt   = (skip_byp || cnt_inc == period) ? 8'h00 : cnt_inc;
        end

        // microstep timing in pixel periods, never below two
        size_raw = fast_feed
                 ? word16(st_r.regs[slot_of(IDX_FAST_HI)], st_r.regs[slot_of(IDX_FAST_LO)])
                 : word16(st_r.regs[slot_of(IDX_SCAN_HI)], st_r.regs[slot_of(IDX_SCAN_LO)]);
        size     = (size_raw < STEP_MIN) ? STEP_MIN : size_raw;
        step_inc = st_r.step_cnt + 16'h0001;
        step_now = motor_run && pixel_tick && (step_inc >= size);
        st_nxt.mot.step = step_now;
        if (!motor_run) begin
            st_nxt.step_cnt  = 16'h0000;
            st_nxt.micro_cnt = 2'h0;
        end else if (pixel_tick) begin
            st_nxt.step_cnt = step_now ? 16'h0000 : step_inc;
        end
        // full step per step pulse, or one full step per four microsteps
        if (step_now) begin
            st_nxt.micro_cnt = st_r.micro_cnt + 2'h1;
            if (!mcfg[MOT_MICRO] || st_r.micro_cnt == MICRO_WRAP) begin
                st_nxt.phase = st_r.phase + 2'h1;
            end
        end

        // two-phase-on pattern, order {b_n, a_n, b, a}
        case (st_r.phase)
            2'h0:    pattern = 4'b0011;
            2'h1:    pattern = 4'b0110;
            2'h2:    pattern = 4'b1100;
            2'h3:    pattern = 4'b1001;
            default: pattern = 4'b0000;
        endcase
        if (!motor_run) begin
            pattern = 4'b0000;                                  // idle leaves windings off
        end
        pol = {mcfg[MOT_POL_B], mcfg[MOT_POL_A], mcfg[MOT_POL_B], mcfg[MOT_POL_A]};
        st_nxt.mot.drv        = pattern ^ pol;
        st_nxt.mot.oe         = {4{mcfg[MOT_DRIVE]}};
        st_nxt.mot.micro_mode = mcfg[MOT_MICRO];
        st_nxt.mot.sense_two  = mcfg[MOT_SENSE2];
    end

    // single state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r                 <= '0;
            st_r.regs            <= {NREG{REG_RST}};
            st_r.rsp.awready     <= 1'b1;
            st_r.rsp.wready      <= 1'b1;
            st_r.rsp.arready     <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign axi_rsp    = st_r.rsp;
    assign pix_out    = st_r.pix;
    assign line_done  = st_r.line_done;
    assign line_store = st_r.line_store;
    assign motor      = st_r.mot;
    assign dram_large = st_r.regs[slot_of(IDX_SRC_CFG)][CFG_DR_SIZE];
endmodule

// ==== pcm_checker_assertions.sv ====
// port-level assertions of the pixel-correction and motor configuration bank
`timescale 1ns/1ns
module pcm_checker
    import pcm_pkg::*;
(
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire pcm_pkg::pcm_axi_req_t axi_req,
    input wire pcm_pkg::pcm_axi_rsp_t axi_rsp,
    input wire pcm_pkg::pcm_pix_in_t  pix_in,
    input wire pcm_pkg::pcm_pix_out_t pix_out,
    input wire logic                  line_end,
    input wire logic                  line_done,
    input wire logic                  line_store,
    input wire logic                  motor_run,
    input wire pcm_pkg::pcm_motor_t   motor
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // bus handshakes that start an answer
    sequence wr_taken;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence rd_taken;
        axi_req.arvalid && axi_rsp.arready;
    endsequence
    AST_WR_ANSWER: assert property (wr_taken |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
        else $error("write answer not two cycles after handshake");
    AST_RD_ANSWER: assert property (rd_taken |=> axi_rsp.rvalid && !axi_rsp.arready)
        else $error("read answer late");
    AST_RD_HOLD: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data dropped before taken");
    AST_PIX_LAT: assert property (pix_in.valid |=> pix_out.valid)
        else $error("pixel not passed one cycle later");
    AST_LINE_DONE: assert property (line_end |=> line_done)
        else $error("line end not reported");
    AST_STORE_DONE: assert property (line_store |-> line_done)
        else $error("line kept without line done");
    AST_OE_ALL: assert property (motor.oe == 4'h0 || motor.oe == 4'hf)
        else $error("phase enables differ");
    AST_STEP_GAP: assert property (motor.step |=> !motor.step)
        else $error("steps closer than two ticks");
    AST_STEP_IDLE: assert property (!motor_run [*2] |=> !motor.step)
        else $error("step while motor idle");
endmodule
bind pcm_top pcm_checker pcm_checker_i (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .pix_in(pix_in), .pix_out(pix_out), .line_end(line_end), .line_done(line_done), .line_store(line_store),
    .motor_run(motor_run), .motor(motor));

// ==== test_pixel_correction_motor_config.sv ====
// self-checking bench of the pixel-correction and motor configuration bank
`timescale 1ns/1ns
module test_pixel_correction_motor_config;
    import pcm_pkg::*;
    logic          aclk, aresetn, line_end, motor_run, fast_feed, pixel_tick, line_done, line_store, dram_large;
    pcm_axi_req_t  req;
    pcm_axi_rsp_t  rsp;
    pcm_pix_in_t   pin;
    pcm_pix_out_t  pout;
    pcm_motor_t    mot;
    int            error_cnt, compares;
    pcm_top pcm_top_i (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .pix_in(pin), .pix_out(pout),
        .dram_large(dram_large), .line_end(line_end), .line_done(line_done), .line_store(line_store),
        .motor_run(motor_run), .fast_feed(fast_feed), .pixel_tick(pixel_tick), .motor(mot));
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bus write, holds each channel until taken; bready stays high between calls
    task wr(input logic [7:0] idx, input logic [31:0] d);
        req.awvalid <= 1'b1; req.awaddr <= {2'h0, idx, 2'h0}; req.wvalid <= 1'b1;
        req.wdata <= d; req.wstrb <= 4'hf; req.bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        chk(rsp.bresp, (idx >= IDX_OFS_HI && idx <= IDX_FAST_LO) ? RESP_OKAY : RESP_SLVERR);
    endtask
    // bus read and compare of data and response; rready stays high between calls
    task rdchk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] eresp);
        req.arvalid <= 1'b1; req.araddr <= {2'h0, idx, 2'h0}; req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        chk(rsp.rdata, exp);
        chk(rsp.rresp, eresp);
    endtask
    task regs_test;
        for (int i = 0; i < 12; i++) rdchk(IDX_OFS_HI + 8'(i), {24'h0, REG_RST}, RESP_OKAY);
        for (int i = 0; i < 12; i++) wr(IDX_OFS_HI + 8'(i), 32'hffffff00 | ((IDX_OFS_HI + i) ^ 8'ha5));
        for (int i = 0; i < 12; i++) rdchk(IDX_OFS_HI + 8'(i), {24'h0, (IDX_OFS_HI + 8'(i)) ^ 8'ha5}, RESP_OKAY);
        chk(dram_large, 1'b1);
        wr(8'h4a, 32'h5a);
        rdchk(8'h4a, 32'h0, RESP_SLVERR);
    endtask
    // one pixel through the correction path
    task pix(input logic [15:0] d, input logic [15:0] g, input logic [15:0] o, input logic [15:0] exp);
        pin <= {1'b1, d, g, o};
        @(posedge aclk);
        pin.valid <= 1'b0;
        #1 chk({pout.valid, pout.data}, {1'b1, exp});
        @(posedge aclk);
    endtask
    task pix_test;
        wr(IDX_OFS_HI, 0);
        wr(IDX_OFS_LO, 32'h10);
        wr(IDX_GAIN_HI, 32'h20);
        wr(IDX_GAIN_LO, 0);
        wr(IDX_SRC_CFG, 0);
        pix(16'h0110, 16'h8000, 16'h0020, 16'h0080);
        wr(IDX_SRC_CFG, 1);
        pix(16'h0110, 16'h8000, 16'h0020, 16'h0100);
        wr(IDX_SRC_CFG, 2);
        pix(16'h0110, 16'h8000, 16'h0020, 16'h0200);
        wr(IDX_SRC_CFG, 5);
        pix(16'h0110, 16'h8000, 16'h0020, 16'h00f0);
        wr(IDX_SRC_CFG, 0);
        pix(16'h0008, 16'h8000, 16'h0020, 16'h0000);
    endtask
    // one line end pulse and its keep decision, starts and ends on an edge
    task line(input logic keep);
        line_end <= 1'b1;
        @(posedge aclk);
        line_end <= 1'b0;
        #1 chk({line_done, line_store}, {1'b1, keep});
        @(posedge aclk);
    endtask
    task line_test;
        wr(IDX_KEEP_T, 32'hfe);
        wr(IDX_PERIOD, 32'h04);
        for (int i = 0; i < 8; i++) line(i % 4 < 2);
        wr(IDX_KEEP_T, 0);
        for (int i = 0; i < 4; i++) line(1'b1);
        wr(IDX_KEEP_T, 32'hfe);
        wr(IDX_PERIOD, 0);
        for (int i = 0; i < 4; i++) line(1'b1);
    endtask
    // motor mode write from an edge, outputs looked at between edges
    task mot_set(input logic [31:0] d);
        @(posedge aclk);
        wr(IDX_MOTOR, d);
        #1;
    endtask
    task mot_test;
        mot_set(32'h11);
        chk({mot.oe, mot.micro_mode, mot.sense_two, mot.drv}, {6'h3e, 4'h0});
        mot_set(32'h02);
        chk({mot.oe, mot.micro_mode, mot.sense_two}, 6'h01);
        mot_set(32'h14);
        chk(mot.drv, 4'h5);
        mot_set(32'h18);
        chk(mot.drv, 4'ha);
        mot_set(32'h10);
        chk(mot.drv, 4'h0);
        @(posedge aclk);
    endtask
    // spacing of two step pulses with a tick every cycle
    task gap(input logic fast, input int exp);
        int n;
        n = 0;
        fast_feed <= fast; motor_run <= 1'b1; pixel_tick <= 1'b1;
        while (mot.step !== 1'b1) @(posedge aclk);
        do begin
            @(posedge aclk);
            n++;
        end while (mot.step !== 1'b1);
        chk(n, exp);
        motor_run <= 1'b0; pixel_tick <= 1'b0;
    endtask
    task step_test;
        wr(IDX_SCAN_HI, 32'h01);
        wr(IDX_SCAN_LO, 32'h02);
        gap(1'b0, 258);
        wr(IDX_FAST_HI, 0);
        wr(IDX_FAST_LO, 32'h01);
        gap(1'b1, 2);
        wr(IDX_FAST_LO, 32'h05);
        gap(1'b1, 5);
    endtask
    task give_verdict;
        if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // reset then scenarios
    initial begin
        req = '0; pin = '0; line_end = 0; motor_run = 0; fast_feed = 0; pixel_tick = 0;
        aresetn = 1'b0; error_cnt = 0; compares = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        regs_test; pix_test; line_test; mot_test; step_test;
        give_verdict;
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        give_verdict;
    end
endmodule
